// ### hw/cmdcfg_consts.svh
// constants of the upper command and configuration block
`ifndef CMDCFG_CONSTS_SVH
`define CMDCFG_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CMD 12'h008
`define OFS_QUANTA 12'h018
`define OFS_SECTION 12'h01c
`define OFS_IRQ_ST 12'h040
`define OFS_IRQ_MASK 12'h044
`define OFS_STATS 12'h100
// ----------------------------------------
// command word fields
// ----------------------------------------
`define B_MAGIC_ENA 19
`define B_DOZE 20
`define B_ALERT 21
`define B_PAUSE 22
`define B_CTRL_ACC 23
`define B_SKIP_CHK 24
`define B_ENA10 25
`define B_DISCARD 26
`define B_RD_TO_OFF 27
`define B_STATS_CLR 31
// ----------------------------------------
// interrupt bits, resets, codes, timing
// ----------------------------------------
`define IRQ_ALERT 0
`define IRQ_PAUSE 1
`define IRQ_CLR_DONE 2
`define IRQ_RD_TO 3
`define IRQ_LEN_ERR 4
`define RST_QUANTA 16'h0000
`define RST_SECTION 16'h0000
`define PAUSE_OPCODE 16'h0001
`define LEN_TYPE_LIMIT 16'h0600
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESP_DECERR 2'b11
`define CLK_PERIOD_PS 8000
`define RD_TIMEOUT_NS 2048
`define RD_TIMEOUT_CYC ((`RD_TIMEOUT_NS * 1000) / `CLK_PERIOD_PS)
`endif

// ### hw/cmdcfg_pkg.sv
// types of the upper command and configuration block
package cmdcfg_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CLEAR = 4'b0010,
    ST_INC = 4'b0100,
    ST_RD = 4'b1000
  } fsm_t;
endpackage

// ### hw/stats_mem.sv
// statistics counter memory with registered read data
`timescale 1ns/1ps
module stats_mem #(
  parameter int AW = 5,
  parameter int DW = 32
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge clk_i)
  begin
    if (en_i && we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_q <= '0;
    end
    else if (en_i && re_i)
    begin
      rdata_q <= mem[addr_i];
    end
  end

  assign rdata_o = rdata_q;
endmodule // stats_mem

// ### hw/rx_frame_filter.sv
// receive verdict for one finished frame
`timescale 1ns/1ps
`include "cmdcfg_consts.svh"
module rx_frame_filter (
  input wire logic ctrl_i,
  input wire logic [15:0] opcode_i,
  input wire logic [15:0] len_field_i,
  input wire logic [15:0] payload_len_i,
  input wire logic bad_i,
  input wire logic ctrl_accept_i,
  input wire logic skip_check_i,
  input wire logic discard_i,
  input wire logic sf_mode_i,
  output logic drop_o,
  output logic err0_o,
  output logic len_err_o
);
  logic is_pause;
  logic bad_any;

  always_comb
  begin
    is_pause = ctrl_i && (opcode_i == `PAUSE_OPCODE);
    // type values carry no length, so only true lengths are compared
    len_err_o = !skip_check_i && !ctrl_i && (len_field_i < `LEN_TYPE_LIMIT)
                && (len_field_i != payload_len_i);
    bad_any = bad_i || len_err_o;
    // pause frames are consumed by the mac itself
    drop_o = (ctrl_i && (is_pause || !ctrl_accept_i))
             || (bad_any && discard_i && sf_mode_i);
    err0_o = bad_any && !drop_o;
  end
endmodule // rx_frame_filter

// ### hw/cmdcfg_upper.sv
// upper command word fields with axi4-lite register slave
`timescale 1ns/1ps
`include "cmdcfg_consts.svh"
module cmdcfg_upper #(
  parameter int STATS_AW = 5,
  parameter int RD_TIMEOUT = `RD_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [11:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic magic_pkt_i,
  input wire logic set_10_i,
  output logic ena_10_o,
  output logic sleep_o,
  output logic pause_req_o,
  output logic [15:0] pause_quanta_o,
  input wire logic pause_ack_i,
  input wire logic rx_done_i,
  input wire logic rx_ctrl_i,
  input wire logic [15:0] rx_opcode_i,
  input wire logic [15:0] rx_len_field_i,
  input wire logic [15:0] rx_payload_len_i,
  input wire logic rx_bad_i,
  output logic rx_valid_o,
  output logic rx_drop_o,
  output logic rx_err0_o,
  output logic rx_len_err_o,
  input wire logic stats_inc_i,
  input wire logic [STATS_AW-1:0] stats_idx_i,
  output logic irq_o
);
  import cmdcfg_pkg::*;

  typedef struct packed {
    logic magic_ena, doze, alert, pause_sr, ctrl_acc, skip_chk, ena10, discard, rd_to_off, stats_clr;
    logic [15:0] quanta;
    logic [15:0] section;
    logic [4:0] irq_st;
    logic [4:0] irq_mask;
    logic irq;
    logic pause_req;
    logic [2:0] sync;
    logic set10, ena10_out, sleep_out;
    logic aw_rdy, aw_full, w_rdy, w_full, bvalid;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] bresp;
    logic ar_rdy, rvalid, rd_pend;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [STATS_AW-1:0] rd_idx;
    logic [15:0] to_cnt;
    fsm_t fsm;
    logic [STATS_AW-1:0] clr_idx;
    logic inc_pend;
    logic [STATS_AW-1:0] inc_idx;
    logic rx_valid, rx_drop, rx_err0, rx_len_err;
  } state_t;

  state_t q_q;
  state_t q_d;
  logic [31:0] cmd_rd;
  logic [31:0] nw;
  logic [4:0] ev;
  logic mem_we;
  logic mem_re;
  logic [STATS_AW-1:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic f_drop;
  logic f_err0;
  logic f_len_err;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_stats(input logic [11:0] a);
    return (a >> (STATS_AW + 2)) == (`OFS_STATS >> (STATS_AW + 2));
  endfunction

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  stats_mem #(
    .AW(STATS_AW),
    .DW(32)
  ) u_stats (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(en_i),
    .we_i(mem_we),
    .re_i(mem_re),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  rx_frame_filter u_filter (
    .ctrl_i(rx_ctrl_i),
    .opcode_i(rx_opcode_i),
    .len_field_i(rx_len_field_i),
    .payload_len_i(rx_payload_len_i),
    .bad_i(rx_bad_i),
    .ctrl_accept_i(q_q.ctrl_acc),
    .skip_check_i(q_q.skip_chk),
    .discard_i(q_q.discard),
    .sf_mode_i(q_q.section == 16'h0000),
    .drop_o(f_drop),
    .err0_o(f_err0),
    .len_err_o(f_len_err)
  );

  // ----------------------------------------
  // command word read view
  // ----------------------------------------
  always_comb
  begin
    cmd_rd = '0;
    cmd_rd[`B_MAGIC_ENA] = q_q.magic_ena;
    cmd_rd[`B_DOZE] = q_q.doze;
    cmd_rd[`B_ALERT] = q_q.alert;
    cmd_rd[`B_PAUSE] = q_q.pause_sr;
    cmd_rd[`B_CTRL_ACC] = q_q.ctrl_acc;
    cmd_rd[`B_SKIP_CHK] = q_q.skip_chk;
    cmd_rd[`B_ENA10] = q_q.ena10;
    cmd_rd[`B_DISCARD] = q_q.discard;
    cmd_rd[`B_RD_TO_OFF] = q_q.rd_to_off;
    cmd_rd[`B_STATS_CLR] = q_q.stats_clr;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    q_d = q_q;
    ev = '0;
    nw = '0;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_addr = '0;
    mem_wdata = '0;
    // force pin: a level counts once the two last stages agree
    q_d.sync = {q_q.sync[1:0], set_10_i};
    if (q_q.sync[2] == q_q.sync[1])
    begin
      q_d.set10 = q_q.sync[2];
    end
    q_d.ena10_out = q_q.ena10 || q_q.set10;
    q_d.sleep_out = q_q.magic_ena && q_q.doze;
    // no fifo level gates the request
    if (q_q.pause_req && pause_ack_i)
    begin
      q_d.pause_req = 1'b0;
      ev[`IRQ_PAUSE] = 1'b1;
    end
    // receive verdict, one pulse per finished frame
    q_d.rx_valid = rx_done_i && !f_drop;
    q_d.rx_drop = rx_done_i && f_drop;
    q_d.rx_err0 = rx_done_i && f_err0;
    q_d.rx_len_err = rx_done_i && f_len_err;
    ev[`IRQ_LEN_ERR] = rx_done_i && f_len_err;
    // read channel
    if (s_axi_arvalid_i && q_q.ar_rdy)
    begin
      q_d.ar_rdy = 1'b0;
      q_d.rvalid = 1'b1;
      q_d.rresp = `RESP_OKAY;
      q_d.rdata = '0;
      case (s_axi_araddr_i)
        `OFS_CMD: q_d.rdata = cmd_rd;
        `OFS_QUANTA: q_d.rdata = {16'h0000, q_q.quanta};
        `OFS_SECTION: q_d.rdata = {16'h0000, q_q.section};
        `OFS_IRQ_ST: q_d.rdata = {27'h0000000, q_q.irq_st};
        `OFS_IRQ_MASK: q_d.rdata = {27'h0000000, q_q.irq_mask};
        default:
        begin
          if (is_stats(s_axi_araddr_i))
          begin
            q_d.rvalid = 1'b0;
            q_d.rd_pend = 1'b1;
            q_d.rd_idx = s_axi_araddr_i[STATS_AW+1:2];
            q_d.to_cnt = '0;
          end
          else
          begin
            q_d.rresp = `RESP_DECERR;
          end
        end
      endcase
    end
    if (q_q.rvalid && s_axi_rready_i)
    begin
      q_d.rvalid = 1'b0;
      q_d.ar_rdy = 1'b1;
    end
    // counter reads can stall behind a clear; give up after the timeout
    if (q_q.rd_pend && q_q.fsm != ST_RD)
    begin
      q_d.to_cnt = q_q.to_cnt + 16'h0001;
      if (!q_q.rd_to_off && q_q.to_cnt == 16'(RD_TIMEOUT - 1))
      begin
        q_d.rd_pend = 1'b0;
        q_d.rvalid = 1'b1;
        q_d.rdata = '0;
        q_d.rresp = `RESP_SLVERR;
        ev[`IRQ_RD_TO] = 1'b1;
      end
    end
    // counter sequencer
    case (q_q.fsm)
      ST_IDLE:
      begin
        if (q_q.stats_clr)
        begin
          q_d.fsm = ST_CLEAR;
          q_d.clr_idx = '0;
        end
        else if (q_q.inc_pend)
        begin
          mem_re = 1'b1;
          mem_addr = q_q.inc_idx;
          q_d.fsm = ST_INC;
        end
        else if (q_q.rd_pend && q_d.rd_pend)
        begin
          mem_re = 1'b1;
          mem_addr = q_q.rd_idx;
          q_d.fsm = ST_RD;
        end
      end
      ST_CLEAR:
      begin
        mem_we = 1'b1;
        mem_addr = q_q.clr_idx;
        q_d.clr_idx = q_q.clr_idx + 1'b1;
        if (&q_q.clr_idx)
        begin
          q_d.stats_clr = 1'b0;
          ev[`IRQ_CLR_DONE] = 1'b1;
          q_d.fsm = ST_IDLE;
        end
      end
      ST_INC:
      begin
        mem_we = 1'b1;
        mem_addr = q_q.inc_idx;
        mem_wdata = mem_rdata + 32'h00000001;
        q_d.inc_pend = 1'b0;
        q_d.fsm = ST_IDLE;
      end
      ST_RD:
      begin
        q_d.rdata = mem_rdata;
        q_d.rresp = `RESP_OKAY;
        q_d.rvalid = 1'b1;
        q_d.rd_pend = 1'b0;
        q_d.fsm = ST_IDLE;
      end
      default: q_d.fsm = ST_IDLE;
    endcase
    // one slot only: a second event before service replaces the first
    if (stats_inc_i)
    begin
      q_d.inc_pend = 1'b1;
      q_d.inc_idx = stats_idx_i;
    end
    // write channel, address and data in either order
    if (s_axi_awvalid_i && q_q.aw_rdy)
    begin
      q_d.aw_full = 1'b1;
      q_d.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q_q.w_rdy)
    begin
      q_d.w_full = 1'b1;
      q_d.w_data = s_axi_wdata_i;
      q_d.w_strb = s_axi_wstrb_i;
    end
    if (q_q.aw_full && q_q.w_full && !q_q.bvalid)
    begin
      q_d.aw_full = 1'b0;
      q_d.w_full = 1'b0;
      q_d.bvalid = 1'b1;
      q_d.bresp = `RESP_OKAY;
      case (q_q.aw_addr)
        `OFS_CMD:
        begin
          nw = merge(cmd_rd, q_q.w_data, q_q.w_strb);
          q_d.magic_ena = nw[`B_MAGIC_ENA];
          q_d.doze = nw[`B_DOZE];
          if (!nw[`B_DOZE])
          begin
            q_d.alert = 1'b0;
          end
          q_d.pause_sr = nw[`B_PAUSE];
          if (nw[`B_PAUSE] && !q_q.pause_sr)
          begin
            q_d.pause_req = 1'b1;
          end
          q_d.ctrl_acc = nw[`B_CTRL_ACC];
          q_d.skip_chk = nw[`B_SKIP_CHK];
          q_d.ena10 = nw[`B_ENA10];
          q_d.discard = nw[`B_DISCARD];
          q_d.rd_to_off = nw[`B_RD_TO_OFF];
          if (nw[`B_STATS_CLR])
          begin
            q_d.stats_clr = 1'b1;
          end
        end
        `OFS_QUANTA: q_d.quanta = 16'(merge({16'h0000, q_q.quanta}, q_q.w_data, q_q.w_strb));
        `OFS_SECTION: q_d.section = 16'(merge({16'h0000, q_q.section}, q_q.w_data, q_q.w_strb));
        `OFS_IRQ_ST: q_d.irq_st = q_q.irq_st & ~(q_q.w_data[4:0] & {5{q_q.w_strb[0]}});
        `OFS_IRQ_MASK: q_d.irq_mask = 5'(merge(32'h00000000, q_q.w_data, q_q.w_strb));
        default: q_d.bresp = is_stats(q_q.aw_addr) ? `RESP_SLVERR : `RESP_DECERR;
      endcase
    end
    if (q_q.bvalid && s_axi_bready_i)
    begin
      q_d.bvalid = 1'b0;
    end
    q_d.aw_rdy = !q_d.aw_full;
    q_d.w_rdy = !q_d.w_full;
    // hardware sets come last so they win over a same-cycle clear
    if (magic_pkt_i && q_q.magic_ena && q_q.doze)
    begin
      q_d.alert = 1'b1;
      ev[`IRQ_ALERT] = 1'b1;
    end
    q_d.irq_st = q_d.irq_st | ev;
    q_d.irq = |(q_d.irq_st & q_d.irq_mask);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      q_q <= '0;
      q_q.aw_rdy <= 1'b1;
      q_q.w_rdy <= 1'b1;
      q_q.ar_rdy <= 1'b1;
      q_q.fsm <= ST_IDLE;
      q_q.quanta <= `RST_QUANTA;
      q_q.section <= `RST_SECTION;
    end
    else if (en_i)
    begin
      q_q <= q_d;
    end
  end

  assign s_axi_awready_o = q_q.aw_rdy;
  assign s_axi_wready_o = q_q.w_rdy;
  assign s_axi_bvalid_o = q_q.bvalid;
  assign s_axi_bresp_o = q_q.bresp;
  assign s_axi_arready_o = q_q.ar_rdy;
  assign s_axi_rvalid_o = q_q.rvalid;
  assign s_axi_rdata_o = q_q.rdata;
  assign s_axi_rresp_o = q_q.rresp;
  assign ena_10_o = q_q.ena10_out;
  assign sleep_o = q_q.sleep_out;
  assign pause_req_o = q_q.pause_req;
  assign pause_quanta_o = q_q.quanta;
  assign rx_valid_o = q_q.rx_valid;
  assign rx_drop_o = q_q.rx_drop;
  assign rx_err0_o = q_q.rx_err0;
  assign rx_len_err_o = q_q.rx_len_err;
  assign irq_o = q_q.irq;
endmodule // cmdcfg_upper

// ### verification/cmdcfg_upper_properties.sv
// concurrent checks on the ports of the upper command word block
`timescale 1ns/1ps
module cmdcfg_upper_checker #(
  parameter int STATS_AW = 5,
  parameter int RD_TIMEOUT = 256
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic set_10_i,
  input wire logic ena_10_o,
  input wire logic pause_req_o,
  input wire logic [15:0] pause_quanta_o,
  input wire logic pause_ack_i,
  input wire logic rx_done_i,
  input wire logic rx_ctrl_i,
  input wire logic [15:0] rx_opcode_i,
  input wire logic [15:0] rx_len_field_i,
  input wire logic [15:0] rx_payload_len_i,
  input wire logic rx_bad_i,
  input wire logic rx_valid_o,
  input wire logic rx_drop_o,
  input wire logic rx_err0_o,
  input wire logic rx_len_err_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------
  // receive verdict
  // ----------------------------------------
  AST_PAUSE_CTRL_DROP: assert property (rx_done_i && en_i && rx_ctrl_i && rx_opcode_i == 16'h0001
    |=> rx_drop_o && !rx_valid_o) else $error("pause control frame not dropped");
  AST_RX_ONE_VERDICT: assert property (rx_done_i && en_i |=> rx_valid_o ^ rx_drop_o)
    else $error("frame neither delivered nor dropped, or both");
  AST_RX_CAUSE: assert property ((rx_valid_o || rx_drop_o) |-> $past(rx_done_i))
    else $error("verdict without a finished frame");
  AST_ERR0_DELIVERED: assert property (rx_err0_o |-> rx_valid_o && !rx_drop_o)
    else $error("error flag on a frame not delivered");
  AST_BAD_FLAGGED: assert property (rx_done_i && en_i && rx_bad_i |=> rx_drop_o || rx_err0_o)
    else $error("bad frame passed without error flag");
  AST_LEN_MATCH: assert property (rx_done_i && en_i && (rx_ctrl_i || rx_len_field_i >= 16'h0600
    || rx_len_field_i == rx_payload_len_i) |=> !rx_len_err_o) else $error("false length error");
  // ----------------------------------------
  // pause and speed
  // ----------------------------------------
  AST_PAUSE_HOLD: assert property (pause_req_o && !pause_ack_i |=> pause_req_o && $stable(pause_quanta_o))
    else $error("pause request or quanta changed before ack");
  AST_PAUSE_ONE: assert property (pause_req_o && pause_ack_i && en_i |=> !pause_req_o)
    else $error("pause request still up after ack");
  // three sync flops, the agreement register and the output register
  AST_FORCE_10: assert property ((set_10_i && en_i) [*6] |-> ena_10_o)
    else $error("force input did not select 10 Mbps");
endmodule // cmdcfg_upper_checker

bind cmdcfg_upper cmdcfg_upper_checker #(.STATS_AW(STATS_AW), .RD_TIMEOUT(RD_TIMEOUT)) chk (.clk_i, .rstn_i,
  .en_i, .set_10_i, .ena_10_o, .pause_req_o, .pause_quanta_o, .pause_ack_i, .rx_done_i, .rx_ctrl_i,
  .rx_opcode_i, .rx_len_field_i, .rx_payload_len_i, .rx_bad_i, .rx_valid_o, .rx_drop_o, .rx_err0_o,
  .rx_len_err_o);

// ### verification/pause_partner.sv
// partner model: transmit side that sends requested pause frames
`timescale 1ns/1ps
module pause_partner (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pause_req_i,
  input wire logic [3:0] delay_i,
  output logic pause_ack_o = 1'h0,
  output int frames_o = 0
);
  logic [3:0] wait_q = 4'h0;
  // a nonzero delay models a busy transmitter; the request must stay up
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pause_ack_o <= 1'h0;
      wait_q <= 4'h0;
      frames_o <= 0;
    end
    else if (pause_req_i && !pause_ack_o && wait_q >= delay_i)
    begin
      pause_ack_o <= 1'h1;
      frames_o <= frames_o + 1;
      wait_q <= 4'h0;
    end
    else
    begin
      pause_ack_o <= 1'h0;
      wait_q <= (pause_req_i && !pause_ack_o) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule // pause_partner

// ### verification/mac_command_config_upper_test.sv
// self-checking bench of the upper command word block
`timescale 1ns/1ps
`include "cmdcfg_consts.svh"
module mac_command_config_upper_test;
  typedef struct {logic [31:0] cmd; logic [15:0] sec, op, ln, pl; logic c, b; logic [3:0] v;} rx_row_t;
  logic clk_i = 1'h0, rstn_i = 1'h0, en_i = 1'h1, magic_pkt_i = 1'h0, set_10_i = 1'h0;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, rx_done_i = 1'h0, rx_ctrl_i = 1'h0;
  logic rx_bad_i = 1'h0, stats_inc_i = 1'h0;
  logic [11:0] s_axi_awaddr_i = 12'h0, s_axi_araddr_i = 12'h0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
  logic [3:0] s_axi_wstrb_i = 4'hf, ack_delay = 4'h0;
  logic [15:0] rx_opcode_i = 16'h0, rx_len_field_i = 16'h0, rx_payload_len_i = 16'h0, pause_quanta_o;
  logic [4:0] stats_idx_i = 5'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, ena_10_o, sleep_o;
  logic pause_req_o, pause_ack_i, rx_valid_o, rx_drop_o, rx_err0_o, rx_len_err_o, irq_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
  int frames, bad_count = 0, total_checks = 0;
  rx_row_t rows [8] = '{
    '{32'h00800000, 16'h0, 16'h0002, 16'h0, 16'h0, 1'h1, 1'h0, 4'h8},
    '{32'h00000000, 16'h0, 16'h0002, 16'h0, 16'h0, 1'h1, 1'h0, 4'h4},
    '{32'h00800000, 16'h0, 16'h0001, 16'h0, 16'h0, 1'h1, 1'h0, 4'h4},
    '{32'h00000000, 16'h0, 16'h0, 16'h0040, 16'h0041, 1'h0, 1'h0, 4'hb},
    '{32'h01000000, 16'h0, 16'h0, 16'h0040, 16'h0041, 1'h0, 1'h0, 4'h8},
    '{32'h04000000, 16'h0, 16'h0, 16'h0800, 16'h0040, 1'h0, 1'h1, 4'h4},
    '{32'h04000000, 16'h5, 16'h0, 16'h0800, 16'h0040, 1'h0, 1'h1, 4'ha},
    '{32'h00000000, 16'h0, 16'h0, 16'h0800, 16'h0040, 1'h0, 1'h1, 4'ha}};

  initial forever #4 clk_i = ~clk_i;

  // small read timeout keeps the run short
  cmdcfg_upper #(.STATS_AW(5), .RD_TIMEOUT(8)) dut (.clk_i, .rstn_i, .en_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_awaddr_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o,
    .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o, .magic_pkt_i, .set_10_i, .ena_10_o, .sleep_o,
    .pause_req_o, .pause_quanta_o, .pause_ack_i, .rx_done_i, .rx_ctrl_i, .rx_opcode_i, .rx_len_field_i,
    .rx_payload_len_i, .rx_bad_i, .rx_valid_o, .rx_drop_o, .rx_err0_o, .rx_len_err_o, .stats_inc_i,
    .stats_idx_i, .irq_o);
  pause_partner peer (.clk_i, .rstn_i, .pause_req_i(pause_req_o), .delay_i(ack_delay),
    .pause_ack_o(pause_ack_i), .frames_o(frames));

  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang_check(input int n);
    if (n >= 400)
    begin
      bad_count++;
      print_verdict();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // the leading edge keeps a handshake signal from being set twice in one step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready_o)
        s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o)
        s_axi_wvalid_i <= 1'h0;
    end while (!s_axi_bvalid_o && n < 400);
    s_axi_bready_i <= 1'h0;
    resp = s_axi_bresp_o;
    hang_check(n);
  endtask

  task automatic rdw(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready_o)
        s_axi_arvalid_i <= 1'h0;
    end while (!s_axi_rvalid_o && n < 400);
    s_axi_rready_i <= 1'h0;
    rd = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    hang_check(n);
  endtask

  task automatic rx(input rx_row_t r);
    wr(`OFS_CMD, r.cmd);
    wr(`OFS_SECTION, {16'h0, r.sec});
    rx_ctrl_i <= r.c;
    rx_opcode_i <= r.op;
    rx_len_field_i <= r.ln;
    rx_payload_len_i <= r.pl;
    rx_bad_i <= r.b;
    rx_done_i <= 1'h1;
    tick(1);
    rx_done_i <= 1'h0;
    tick(1);
    rd = {28'h0, rx_valid_o, rx_drop_o, rx_err0_o, rx_len_err_o};
  endtask

  task automatic pulse_magic();
    magic_pkt_i <= 1'h1;
    tick(1);
    magic_pkt_i <= 1'h0;
    tick(3);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    tick(20);
    rstn_i <= 1'h1;
    rdw(`OFS_CMD);
    chk(rd, 32'h0);
    rdw(12'h004);
    chk(32'(resp), 32'(`RESP_DECERR));
    wr(`OFS_STATS, 32'h1);
    chk(32'(resp), 32'(`RESP_SLVERR));
    wr(`OFS_CMD, 32'h02000000);
    tick(3);
    chk(32'(ena_10_o), 32'h1);
    wr(`OFS_CMD, 32'h0);
    tick(3);
    chk(32'(ena_10_o), 32'h0);
    set_10_i <= 1'h1;
    tick(8);
    chk(32'(ena_10_o), 32'h1);
    set_10_i <= 1'h0;
    wr(`OFS_IRQ_MASK, 32'h1);
    pulse_magic();
    rdw(`OFS_CMD);
    chk(rd, 32'h0);
    wr(`OFS_CMD, 32'h00180000);
    tick(3);
    chk(32'(sleep_o), 32'h1);
    pulse_magic();
    rdw(`OFS_CMD);
    chk(rd, 32'h00380000);
    chk(32'(irq_o), 32'h1);
    wr(`OFS_CMD, 32'h00080000);
    rdw(`OFS_CMD);
    chk(rd, 32'h00080000);
    wr(`OFS_IRQ_ST, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h2);
    wr(`OFS_QUANTA, 32'h1234);
    wr(`OFS_CMD, 32'h00400000);
    chk(32'(pause_quanta_o), 32'h1234);
    tick(10);
    chk(32'(frames), 32'h1);
    chk(32'(irq_o), 32'h1);
    wr(`OFS_CMD, 32'h00400000);
    tick(10);
    chk(32'(frames), 32'h1);
    wr(`OFS_CMD, 32'h0);
    ack_delay <= 4'hc;
    wr(`OFS_CMD, 32'h00400000);
    tick(4);
    chk(32'(pause_req_o), 32'h1);
    tick(20);
    chk(32'(frames), 32'h2);
    wr(`OFS_IRQ_ST, 32'h2);
    tick(2);
    chk(32'(irq_o), 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      rx(rows[i]);
      chk(rd, {28'h0, rows[i].v});
    end
    // clock enable low must freeze the force synchroniser
    en_i <= 1'h0;
    set_10_i <= 1'h1;
    tick(8);
    chk(32'(ena_10_o), 32'h0);
    set_10_i <= 1'h0;
    en_i <= 1'h1;
    tick(2);
    // counters power up unknown, so clear them before counting
    wr(`OFS_CMD, 32'h80000000);
    rdw(`OFS_STATS);
    chk(32'(resp), 32'(`RESP_SLVERR));
    for (int i = 0; i < 20; i++)
    begin
      rdw(`OFS_CMD);
      if (rd === 32'h0)
        break;
    end
    chk(rd, 32'h0);
    repeat (3)
    begin
      stats_idx_i <= 5'h3;
      stats_inc_i <= 1'h1;
      tick(1);
      stats_inc_i <= 1'h0;
      tick(4);
    end
    rdw(`OFS_STATS + 12'h00c);
    chk(rd, 32'h3);
    wr(`OFS_CMD, 32'h88000000);
    rdw(`OFS_STATS);
    chk(32'(resp), 32'(`RESP_OKAY));
    rdw(`OFS_STATS + 12'h00c);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule // mac_command_config_upper_test
